// ===== pcr_consts.svh
// Offsets, reset values, field positions and fixed values of the packet client registers
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
// Register indices; the byte address is four times the index
`define PCR_IDX_SCRATCH    14'h1000
`define PCR_IDX_IDENT      14'h1001
`define PCR_IDX_FEATURE    14'h1002
`define PCR_IDX_TEMP       14'h1006
`define PCR_IDX_TXCTL      14'h1010
`define PCR_IDX_LBERR      14'h1015
`define PCR_IDX_LBRST      14'h1016
// Reset values
`define PCR_RST_SCRATCH    32'h0000_0000
`define PCR_RST_TXCTL      4'h5
`define PCR_RST_LBERR_CLR  1'h0
`define PCR_RST_LBRST      1'h0
`define PCR_RST_RDATA      32'h0000_0000
// Transmit control fields
`define PCR_TXCTL_GEN_DIS  1
`define PCR_TXCTL_LB_MODE  3
// Loopback error fields
`define PCR_LBERR_UNDER    0
`define PCR_LBERR_OVER     1
`define PCR_LBERR_CLR      2
// Fixed feature bits
`define PCR_FEAT_MAC_VAR   1'h0
`define PCR_FEAT_RSVD4     1'h0
`define PCR_FEAT_EXT_PLL   1'h0
`define PCR_FEAT_STD_IF    1'h1
// Widths
`define PCR_FEAT_W         10
`define PCR_TEMP_W         8
`define PCR_TXCTL_W        4
`endif

// ===== pcr_pkg.sv
// Types shared by the packet client register files
`default_nettype none
package pcr_pkg;
  // One register bus request from software
  typedef struct packed {
    logic [15:0] addr;   // Byte address
    logic [31:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } pcr_bus_req_t;
  // Error events from the loopback FIFO, same clock
  typedef struct packed {
    logic overflow;      // FIFO written while full
    logic underflow;     // FIFO read while empty
  } pcr_fifo_evt_t;
endpackage
`default_nettype wire

// ===== pcr_sync.sv
// Three-stage synchroniser with an agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pcr_sync
#(
  parameter int W = 8
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] meta_q;  // First stage, read only by the second
  logic [W-1:0] s2_q;    // Second stage
  logic [W-1:0] s3_q;    // Third stage

  // Shift chain; the first flop may go metastable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  // Accept a value only once two stages agree, so a word caught mid-change never shows
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      level_q <= '0;
    else if (s2_q == s3_q)
      level_q <= s3_q;
  end

  property p_sync_agree;
    @(posedge mclk) disable iff (!rst_n)
    (level_q != $past(level_q)) |-> ($past(s2_q) == $past(s3_q)) && (level_q == $past(s3_q));
  endproperty
  a_sync_agree: assert property (p_sync_agree)
    else $error("synchroniser output changed without agreement");
endmodule
`default_nettype wire

// ===== pcr_sticky.sv
// Sticky error flag: hardware sets, software clears, set wins
`timescale 1ns/10ps
`default_nettype none
module pcr_sticky
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  // Set beats clear so an event in the clearing cycle is not lost
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'h0;
    else if (set)
      flag_q <= 1'h1;
    else if (clr)
      flag_q <= 1'h0;
  end

  property p_set_wins;
    @(posedge mclk) disable iff (!rst_n)
    set |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event did not set sticky flag");

  property p_flag_holds;
    @(posedge mclk) disable iff (!rst_n)
    (flag_q && !clr) |=> flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("sticky flag dropped without a clear");

  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
    (clr && !set) |=> !flag_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not drop sticky flag");
endmodule
`default_nettype wire

// ===== pcr_regs.sv
// Packet client control and status register bank
//
// How it works
// - scratch word reads back what was written
// - read-only identification word, fixed four characters
// - feature bits 0-2: family, variant, refclk
// - feature bits 8-3 report core properties
// - feature bit 9 reads one, standard interface
// - read-only 8-bit die temperature in Fahrenheit
// - txctl bit 1 disables generator; reset 0101
// - txctl bit 3 selects MAC loopback mode
// - underflow flag sets and stays set
// - overflow flag sets and stays set
// - error bit 2 clears both flags
// - writing one holds loopback path reset
`timescale 1ns/10ps
`default_nettype none
`include "pcr_consts.svh"
module pcr_regs
#(
  parameter logic [31:0] IDENT_WORD   = 32'h4142_4344,  // Arbitrary neutral value
  parameter bit          FAMILY_ALT   = 1'b0,           // Second target family
  parameter bit          REFCLK_644   = 1'b0,           // Reference clock is 644 MHz
  parameter bit          HAS_BACKPLN  = 1'b0,           // Backplane variant
  parameter bit          HAS_TSTAMP   = 1'b0,           // Time-stamping support
  parameter bit          HAS_PAUSE    = 1'b0,           // Pause support
  parameter bit          HAS_LFAULT   = 1'b0            // Local fault signaling
)
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire pcr_pkg::pcr_bus_req_t bus_req,
  output logic [31:0]                rd_data_q,
  input  wire logic [7:0]            die_temp_pin,
  input  wire pcr_pkg::pcr_fifo_evt_t fifo_evt,
  output logic                       gen_disable_q,
  output logic                       loopback_mode_q,
  output logic                       loopback_rst_q
);

  // Reset pattern of transmit control, kept sized so single bits can be picked
  localparam logic [`PCR_TXCTL_W-1:0] TXCTL_RST = `PCR_RST_TXCTL;

  // interface type bit
  // Feature vector is fixed by the build
  localparam logic [`PCR_FEAT_W-1:0] FEATURE = {
    `PCR_FEAT_STD_IF,
    `PCR_FEAT_EXT_PLL,
    HAS_LFAULT,
    HAS_PAUSE,
    HAS_TSTAMP,
    `PCR_FEAT_RSVD4,
    HAS_BACKPLN,
    REFCLK_644,
    `PCR_FEAT_MAC_VAR,
    FAMILY_ALT
  };

  // Byte address match for a register index; low two bits must be zero
  function automatic logic addr_hit(input logic [15:0] addr, input logic [13:0] idx);
    addr_hit = (addr == {idx, 2'b00});
  endfunction

  // Stored state
  logic [31:0]              scratch_q;   // Free scratch word
  logic [`PCR_TXCTL_W-1:0]  txctl_q;     // Transmit control, all four bits kept
  logic                     err_clr_q;   // Clear request for both error flags
  logic                     underflow_q; // Sticky underflow flag
  logic                     overflow_q;  // Sticky overflow flag
  logic [`PCR_TEMP_W-1:0]   temp_q;      // Synchronised temperature reading

  // Decoded strobes
  logic                     wr_scratch;  // Write to scratch
  logic                     wr_txctl;    // Write to transmit control
  logic                     wr_lberr;    // Write to loopback errors
  logic                     wr_lbrst;    // Write to loopback reset
  logic [31:0]              rd_mux;      // Data selected for a read

  // Write address decode
  always_comb
  begin
    wr_scratch = 1'b0;
    wr_txctl   = 1'b0;
    wr_lberr   = 1'b0;
    wr_lbrst   = 1'b0;
    if (!bus_req.wr)
    begin
      // No write this cycle
      wr_scratch = 1'b0;
    end
    else if (addr_hit(bus_req.addr, `PCR_IDX_SCRATCH))
      wr_scratch = 1'b1;
    else if (addr_hit(bus_req.addr, `PCR_IDX_TXCTL))
      wr_txctl = 1'b1;
    else if (addr_hit(bus_req.addr, `PCR_IDX_LBERR))
      wr_lberr = 1'b1;
    else if (addr_hit(bus_req.addr, `PCR_IDX_LBRST))
      wr_lbrst = 1'b1;
    // Writes to read-only or unmapped words are ignored
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      scratch_q <= `PCR_RST_SCRATCH;
    else if (wr_scratch)
      scratch_q <= bus_req.wdata;
  end

  // transmit control store
  // Reserved bits 0 and 2 are kept as written so the reset pattern reads back
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      txctl_q <= `PCR_RST_TXCTL;
    else if (wr_txctl)
      txctl_q <= bus_req.wdata[`PCR_TXCTL_W-1:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gen_disable_q   <= TXCTL_RST[`PCR_TXCTL_GEN_DIS];
      loopback_mode_q <= TXCTL_RST[`PCR_TXCTL_LB_MODE];
    end
    else if (wr_txctl)
    begin
      // Outputs track the stored bits in the same edge
      gen_disable_q   <= bus_req.wdata[`PCR_TXCTL_GEN_DIS];
      loopback_mode_q <= bus_req.wdata[`PCR_TXCTL_LB_MODE];
    end
  end

  // error clear request
  // Level held by software; while it is one, a flag set by an event clears again on the next edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      err_clr_q <= `PCR_RST_LBERR_CLR;
    else if (wr_lberr)
      err_clr_q <= bus_req.wdata[`PCR_LBERR_CLR];
  end

  pcr_sticky u_underflow
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set    (fifo_evt.underflow),
    .clr    (err_clr_q),
    .flag_q (underflow_q)
  );

  pcr_sticky u_overflow
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set    (fifo_evt.overflow),
    .clr    (err_clr_q),
    .flag_q (overflow_q)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      loopback_rst_q <= `PCR_RST_LBRST;
    else if (wr_lbrst)
      loopback_rst_q <= bus_req.wdata[0];
  end

  // temperature pin synchroniser
  // The sensor word changes asynchronously, so a word is taken only when stable
  pcr_sync
  #(
    .W (`PCR_TEMP_W)
  )
  u_temp_sync
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  (die_temp_pin),
    .level_q (temp_q)
  );

  // Read address decode; unmapped words read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr_hit(bus_req.addr, `PCR_IDX_SCRATCH))
      rd_mux = scratch_q;
    else if (addr_hit(bus_req.addr, `PCR_IDX_IDENT))
      rd_mux = IDENT_WORD;
    else if (addr_hit(bus_req.addr, `PCR_IDX_FEATURE))
      rd_mux = {22'h00_0000, FEATURE};
    else if (addr_hit(bus_req.addr, `PCR_IDX_TEMP))
      rd_mux = {24'h00_0000, temp_q};
    else if (addr_hit(bus_req.addr, `PCR_IDX_TXCTL))
      rd_mux = {28'h000_0000, txctl_q};
    // flags and clear bit read together
    else if (addr_hit(bus_req.addr, `PCR_IDX_LBERR))
      rd_mux = {29'h0000_0000, err_clr_q, overflow_q, underflow_q};
    else if (addr_hit(bus_req.addr, `PCR_IDX_LBRST))
      rd_mux = {31'h0000_0000, loopback_rst_q};
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_q <= `PCR_RST_RDATA;
    else if (bus_req.rd)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= `PCR_RST_RDATA;
  end

  // Checks on the bank's own behaviour

  property p_scratch_rb;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.wr && addr_hit(bus_req.addr, `PCR_IDX_SCRATCH)) ##1
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_SCRATCH))
    |=> rd_data_q == $past(bus_req.wdata, 2);
  endproperty
  a_scratch_rb: assert property (p_scratch_rb)
    else $error("scratch did not read back written value");

  property p_ident;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_IDENT)) |=> rd_data_q == IDENT_WORD;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identification word wrong");

  property p_feat_low;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_FEATURE))
    |=> rd_data_q[2:0] == {REFCLK_644, 1'b0, FAMILY_ALT};
  endproperty
  a_feat_low: assert property (p_feat_low)
    else $error("feature bits 2..0 wrong");

  property p_feat_mid;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_FEATURE))
    |=> (rd_data_q[8] == 1'b0) && (rd_data_q[3] == HAS_BACKPLN) && (rd_data_q[7] == HAS_LFAULT);
  endproperty
  a_feat_mid: assert property (p_feat_mid)
    else $error("feature bits 8..3 wrong");

  property p_feat_top;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_FEATURE))
    |=> (rd_data_q[9] == 1'b1) && (rd_data_q[31:10] == 22'h00_0000);
  endproperty
  a_feat_top: assert property (p_feat_top)
    else $error("feature bit 9 or upper bits wrong");

  property p_temp;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_TEMP))
    |=> rd_data_q == {24'h00_0000, $past(temp_q)};
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature readout wrong");

  property p_gen_dis;
    @(posedge mclk) disable iff (!rst_n)
    wr_txctl |=> (gen_disable_q == $past(bus_req.wdata[1])) && (txctl_q == $past(bus_req.wdata[3:0]));
  endproperty
  a_gen_dis: assert property (p_gen_dis)
    else $error("generator disable did not follow write");

  property p_lb_mode;
    @(posedge mclk) disable iff (!rst_n)
    !wr_txctl |=> $stable(loopback_mode_q) && (loopback_mode_q == txctl_q[3]);
  endproperty
  a_lb_mode: assert property (p_lb_mode)
    else $error("loopback mode changed without a write");

  property p_err_read;
    @(posedge mclk) disable iff (!rst_n)
    fifo_evt.underflow ##1 (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_LBERR)) |=> rd_data_q[0];
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("underflow not visible after event");

  property p_ovf_clear;
    @(posedge mclk) disable iff (!rst_n)
    (err_clr_q && !fifo_evt.overflow) ##1 (err_clr_q && !fifo_evt.overflow) |-> !overflow_q;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag survived a clear");

  property p_lbrst_set;
    @(posedge mclk) disable iff (!rst_n)
    (wr_lbrst && bus_req.wdata[0]) |=> loopback_rst_q;
  endproperty
  a_lbrst_set: assert property (p_lbrst_set)
    else $error("loopback reset not taken");

  property p_lbrst_hold;
    @(posedge mclk) disable iff (!rst_n)
    (loopback_rst_q && !wr_lbrst) |=> loopback_rst_q;
  endproperty
  a_lbrst_hold: assert property (p_lbrst_hold)
    else $error("loopback reset released without a write");

  property p_rd_idle;
    @(posedge mclk) disable iff (!rst_n)
    !bus_req.rd |=> rd_data_q == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data present without a read");

  property p_feat_props;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_FEATURE))
    |=> (rd_data_q[4] == 1'b0) && (rd_data_q[5] == HAS_TSTAMP) && (rd_data_q[6] == HAS_PAUSE);
  endproperty
  a_feat_props: assert property (p_feat_props)
    else $error("feature bits 6..4 wrong");

  property p_lberr_clr_bit;
    @(posedge mclk) disable iff (!rst_n)
    (bus_req.rd && addr_hit(bus_req.addr, `PCR_IDX_LBERR)) |=> rd_data_q[2] == $past(err_clr_q);
  endproperty
  a_lberr_clr_bit: assert property (p_lberr_clr_bit)
    else $error("clear bit readback wrong");

  property p_lbrst_clear;
    @(posedge mclk) disable iff (!rst_n)
    (wr_lbrst && !bus_req.wdata[0]) |=> !loopback_rst_q;
  endproperty
  a_lbrst_clear: assert property (p_lbrst_clear)
    else $error("loopback reset not released by a zero write");
endmodule
`default_nettype wire

// ===== pcr_client_model.sv
// Far-side model: loopback FIFO error events and the temperature sensor pins
`timescale 1ns/10ps
`default_nettype none
module pcr_client_model
(
  input  wire logic              mclk,
  output var pcr_pkg::pcr_fifo_evt_t fifo_evt,
  output var logic [7:0]         temp_pin
);
  // Quiet FIFO and a cold sensor at time zero
  initial
  begin
    fifo_evt = '0;
    temp_pin = 8'h00;
  end

  task automatic fifo_event(input logic over, input logic under);
    @(posedge mclk);
    fifo_evt <= '{overflow: over, underflow: under};
    @(posedge mclk);
    fifo_evt <= '0;
  endtask

  task automatic set_temp(input logic [7:0] val);
    // Called just after an edge, so the pin moves away from sampling
    temp_pin <= val;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the packet client register bank
`timescale 1ns/10ps
`default_nettype none
`include "pcr_consts.svh"
module tb_top;
  localparam logic [31:0] ID_WORD = 32'h5A3C_1E0F;  // Arbitrary identification value

  logic                   mclk;             // 20 MHz clock
  logic                   rst_n;            // Active-low reset
  pcr_pkg::pcr_bus_req_t  bus_req;          // Register bus request
  logic [31:0]            rd_data_q;        // Read data
  logic [7:0]             die_temp_pin;     // Sensor pins from the model
  pcr_pkg::pcr_fifo_evt_t fifo_evt;         // FIFO events from the model
  logic                   gen_disable_q;    // Generator off
  logic                   loopback_mode_q;  // Loopback mode
  logic                   loopback_rst_q;   // Loopback path reset
  integer                 fail_count;       // Mismatches
  integer                 tests_run;        // Comparisons
  integer                 seed;             // Random seed
  logic [31:0]            v;                // Stimulus value

  pcr_regs #(.IDENT_WORD(ID_WORD)) u_pcr_regs
  (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .bus_req         (bus_req),
    .rd_data_q       (rd_data_q),
    .die_temp_pin    (die_temp_pin),
    .fifo_evt        (fifo_evt),
    .gen_disable_q   (gen_disable_q),
    .loopback_mode_q (loopback_mode_q),
    .loopback_rst_q  (loopback_rst_q)
  );

  pcr_client_model u_pcr_client_model
  (
    .mclk     (mclk),
    .fifo_evt (fifo_evt),
    .temp_pin (die_temp_pin)
  );

  // Byte address of a register index
  function automatic logic [15:0] addr_of(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction

  // Feature word for the default core properties
  function automatic logic [31:0] feat_exp();
    return {22'h0, `PCR_FEAT_STD_IF, `PCR_FEAT_EXT_PLL, 8'h00};
  endfunction

  // Free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Compare and report
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One write cycle; the next call or idle drops the strobe
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
  endtask

  // One read cycle; data is taken in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, output logic [31:0] g);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    // Take the data mid-cycle, where it has settled
    @(negedge mclk);
    g = rd_data_q;
    @(posedge mclk);
  endtask

  // Bus quiet for one cycle
  task automatic idle();
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    @(posedge mclk);
  endtask

  // Read and compare
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] g;
    reg_rd(a, g);
    check(g, e);
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge mclk);
    fail_count = fail_count + 1;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    seed = 74;
    rst_n = 1'b0;
    bus_req = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check({29'h0, gen_disable_q, loopback_mode_q, loopback_rst_q}, 32'h0);
    rd_chk(addr_of(`PCR_IDX_SCRATCH), `PCR_RST_SCRATCH);
    rd_chk(addr_of(`PCR_IDX_IDENT), ID_WORD);
    rd_chk(addr_of(`PCR_IDX_FEATURE), feat_exp());
    rd_chk(addr_of(`PCR_IDX_TXCTL), 32'h0000_0005);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h0);
    rd_chk(addr_of(`PCR_IDX_LBRST), 32'h0);
    // Read-only words ignore writes
    reg_wr(addr_of(`PCR_IDX_IDENT), ~ID_WORD);
    rd_chk(addr_of(`PCR_IDX_IDENT), ID_WORD);
    reg_wr(addr_of(`PCR_IDX_FEATURE), 32'hFFFF_FFFF);
    rd_chk(addr_of(`PCR_IDX_FEATURE), feat_exp());
    rd_chk(addr_of(`PCR_IDX_FEATURE), feat_exp());
    // Scratch: corners first, then random, back-to-back with reads
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : $random(seed);
      reg_wr(addr_of(`PCR_IDX_SCRATCH), v);
      rd_chk(addr_of(`PCR_IDX_SCRATCH), v);
    end
    // Unaligned and unmapped places read zero, and read data lasts one cycle
    rd_chk(addr_of(`PCR_IDX_SCRATCH) + 16'h0001, 32'h0);
    reg_wr(16'h4010, 32'hFFFF_FFFF);
    rd_chk(16'h4010, 32'h0);
    idle();
    check(rd_data_q, 32'h0);
    // Transmit control: corners then random values
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : (i == 2) ? 32'hA : $random(seed);
      reg_wr(addr_of(`PCR_IDX_TXCTL), v);
      idle();
      check({31'h0, gen_disable_q}, {31'h0, v[`PCR_TXCTL_GEN_DIS]});
      check({31'h0, loopback_mode_q}, {31'h0, v[`PCR_TXCTL_LB_MODE]});
      rd_chk(addr_of(`PCR_IDX_TXCTL), {28'h0, v[3:0]});
    end
    // Temperature follows the sensor after the synchroniser
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      u_pcr_client_model.set_temp(v[7:0]);
      repeat (6) @(posedge mclk);
      rd_chk(addr_of(`PCR_IDX_TEMP), {24'h0, v[7:0]});
    end
    // Sticky flags, clear level, re-arm
    u_pcr_client_model.fifo_event(1'b0, 1'b1);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h1);
    repeat (10) @(posedge mclk);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h1);
    u_pcr_client_model.fifo_event(1'b1, 1'b0);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h3);
    reg_wr(addr_of(`PCR_IDX_LBERR), 32'h4);
    idle();
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h4);
    reg_wr(addr_of(`PCR_IDX_LBERR), 32'h0);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h0);
    u_pcr_client_model.fifo_event(1'b1, 1'b0);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h2);
    // Loopback reset holds until written back to zero
    reg_wr(addr_of(`PCR_IDX_LBRST), 32'hFFFF_FFFF);
    idle();
    check({31'h0, loopback_rst_q}, 32'h1);
    repeat (20) @(posedge mclk);
    check({31'h0, loopback_rst_q}, 32'h1);
    rd_chk(addr_of(`PCR_IDX_LBRST), 32'h1);
    reg_wr(addr_of(`PCR_IDX_LBRST), 32'h0);
    idle();
    check({31'h0, loopback_rst_q}, 32'h0);
    // Reset in mid-run restores the reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check({29'h0, gen_disable_q, loopback_mode_q, loopback_rst_q}, 32'h0);
    rd_chk(addr_of(`PCR_IDX_TXCTL), 32'h0000_0005);
    rd_chk(addr_of(`PCR_IDX_LBERR), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
